// [src/anpd_consts.vh]
// constants shared by the auto-negotiation support block
`ifndef ANPD_CONSTS_VH
`define ANPD_CONSTS_VH
`define ANPD_A_CTRL     5'h00
`define ANPD_A_STAT     5'h01
`define ANPD_A_ADV      5'h04
`define ANPD_A_LPA      5'h05
`define ANPD_A_EXP      5'h06
`define ANPD_A_CSTAT    5'h11
`define ANPD_A_VEND     5'h13
`define ANPD_B_SWRST    15
`define ANPD_B_ANEN     12
`define ANPD_B_RESTART  9
`define ANPD_B_CPLT1    5
`define ANPD_B_RF1      4
`define ANPD_B_LINK1    2
`define ANPD_B_NP       15
`define ANPD_B_ACK      14
`define ANPD_B_RF       13
`define ANPD_B_AB_HI    8
`define ANPD_B_AB_LO    5
`define ANPD_B_10H      5
`define ANPD_B_100H     7
`define ANPD_B_SEL_HI   4
`define ANPD_B_LPCAP    0
`define ANPD_B_PDF      4
`define ANPD_B_RATE     15
`define ANPD_B_DPX      14
`define ANPD_B_PM_HI    13
`define ANPD_B_PM_LO    11
`define ANPD_B_CPLT17   4
`define ANPD_B_NOSIG    3
`define ANPD_B_RF17     1
`define ANPD_B_LINK17   0
`define ANPD_B_SLOW     0
`define ANPD_T_100F     3
`define ANPD_T_100H     2
`define ANPD_T_10F      1
`define ANPD_T_10H      0
`define ANPD_SEL        5'h01
`define ANPD_ADV_RST    4'hf
`define ANPD_PC_IDLE    3'h0
`define ANPD_PC_BRK     3'h1
`define ANPD_PC_ABL     3'h2
`define ANPD_PC_ACK     3'h3
`define ANPD_PC_CACK    3'h4
`define ANPD_PC_PDET    3'h5
`define ANPD_PC_LCHK    3'h6
`define ANPD_PC_UP      4'h8
`define ANPD_PC_DONE    4'hf
`define ANPD_CLK_MHZ    100
`define ANPD_BREAK_US   1200
`define ANPD_RESP_US    10000
`define ANPD_LINK_US    50000
`define ANPD_TYP_MS     500
`endif

// [src/anpd_detect.v]
// line classifier and common-technology priority resolution
`timescale 1ns/10ps
`include "anpd_consts.vh"
module anpd_detect (
   input  wire       flp,
   input  wire       nlp,
   input  wire       idle100,
   input  wire [3:0] adv,
   input  wire [3:0] lpa,
   output wire       sig_none,
   output wire       multi,
   output wire       only_flp,
   output wire       only_nlp,
   output wire       only_idle,
   output wire       res_ok,
   output wire       res_100,
   output wire       res_fd
);
   wire [1:0] seen;
   wire [3:0] common;

   assign seen      = {1'b0, flp} + {1'b0, nlp} + {1'b0, idle100};
   assign sig_none  = (seen == 2'h0);
   // more than one kind of signal at once cannot be resolved
   assign multi     = (seen > 2'h1);
   assign only_flp  = flp & ~multi;
   assign only_nlp  = nlp & ~multi;
   assign only_idle = idle100 & ~multi;
   assign common    = adv & lpa;
   // order: 100 full, 100 half, 10 full, 10 half; the 4-pair mode is never offered
   assign res_ok    = |common;
   assign res_100   = common[`ANPD_T_100F] | common[`ANPD_T_100H];
   assign res_fd    = common[`ANPD_T_100F] |
                      (~common[`ANPD_T_100H] & common[`ANPD_T_10F]);
endmodule

// [src/anpd_progress.v]
// progress monitor: latches the highest arbitration state reached
`timescale 1ns/10ps
`include "anpd_consts.vh"
module anpd_progress (
   input  wire       clk,
   input  wire       rst,
   input  wire       clr,
   input  wire       rd,
   input  wire [2:0] arb,
   input  wire       cplt,
   output wire [3:0] held
);
   reg  [3:0] held_reg;
   wire [3:0] present;
   wire [3:0] cand;

   // a finished negotiation is seen as up (8h) now, but as done (fh) in history
   assign present = cplt ? `ANPD_PC_UP : {1'b0, arb};
   assign cand    = cplt ? `ANPD_PC_DONE : {1'b0, arb};
   assign held    = held_reg;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         held_reg <= 4'h0;
      end else if (clr) begin
         held_reg <= 4'h0;
      end else if (rd) begin
         held_reg <= present;
      end else if (!held_reg[3] && (cand > held_reg)) begin
         // once the complete bit is held only a read or reset moves it
         held_reg <= cand;
      end
   end
endmodule

// [src/anpd_top.v]
// auto-negotiation arbitration, parallel detection and progress monitor
//
// Overview of operation
// - no negotiating reply clears partner-capable bit
// - parallel detect sets partner bit 5.5 or 5.7
// - parallel detect success sets negotiation complete
// - enable detected technology, disable all others
// - link pulses mean 10M; scrambled idles mean 100M
// - FLP reply sets partner-capable bit
// - no receive signal sets signal-detect bit
// - several technologies at once set detection fault
// - partner remote fault sets four fault bits
// - local link fault advertised as remote fault
// - negotiate after power-up and on request
// - any reset idles machine, clears progress bits
// - restart reinitialises machine, keeps progress bits
// - after completion only read or reset alter
// - restart on link loss, restart bit, enable toggle
// - consolidated status shows rate, duplex, link, complete
// - progress code: complete bit over three bits
// - progress code values 0 to 6, 8 and fh
// - latch arbitration state only when it is higher
// - read returns history, then loads present state
// - first read after completion 111, then 000
// - negotiation typically done within 500 ms
// - priority resolution over common advertised technologies
// - transmitted bursts carry the advertisement register
//
// The implementer's own choices: strobed register access and the address map.
`timescale 1ns/10ps
`include "anpd_consts.vh"
module anpd_top #(
   parameter CW        = 26,
   parameter BREAK_CYC = `ANPD_BREAK_US * `ANPD_CLK_MHZ,
   parameter RESP_CYC  = `ANPD_RESP_US * `ANPD_CLK_MHZ,
   parameter LINK_CYC  = `ANPD_LINK_US * `ANPD_CLK_MHZ,
   parameter TYP_CYC   = `ANPD_TYP_MS * 1000 * `ANPD_CLK_MHZ
) (
   input  wire        CLK,
   input  wire        SYS_RST,
   input  wire [4:0]  REG_ADDR,
   input  wire [15:0] REG_WDATA,
   input  wire        REG_WR,
   input  wire        REG_RD,
   output wire [15:0] REG_RDATA,
   input  wire        FLP_RX,
   input  wire [15:0] FLP_WORD,
   input  wire        NLP_RX,
   input  wire        IDLE100_RX,
   input  wire        LINK_OK,
   input  wire        LOCAL_FAULT,
   output wire        FLP_TX_EN,
   output wire [15:0] FLP_TX_WORD,
   output wire        TECH_100_EN,
   output wire        TECH_10_EN,
   output wire        FULL_DUPLEX
);
   localparam [7:0] S_IDLE = 8'h01;
   localparam [7:0] S_BRK  = 8'h02;
   localparam [7:0] S_ABL  = 8'h04;
   localparam [7:0] S_ACK  = 8'h08;
   localparam [7:0] S_CACK = 8'h10;
   localparam [7:0] S_PDET = 8'h20;
   localparam [7:0] S_LCHK = 8'h40;
   localparam [7:0] S_DONE = 8'h80;

   // counts are worked out at 32 bits, then cut to the counter width on purpose
   localparam [31:0]   BRK_W     = BREAK_CYC - 1;
   localparam [31:0]   RESP_W    = RESP_CYC - 1;
   localparam [31:0]   LINK_W    = LINK_CYC - 1;
   localparam [31:0]   TYP_W     = TYP_CYC - 1;
   localparam [CW-1:0] BRK_LAST  = BRK_W[CW-1:0];
   localparam [CW-1:0] RESP_LAST = RESP_W[CW-1:0];
   localparam [CW-1:0] LINK_LAST = LINK_W[CW-1:0];
   localparam [CW-1:0] TYP_LAST  = TYP_W[CW-1:0];
   localparam [CW-1:0] CNT_ONE   = {{(CW-1){1'b0}}, 1'b1};

   reg  [7:0]    state_reg;
   reg  [7:0]    state_next;
   reg  [CW-1:0] cnt_reg;
   reg  [CW-1:0] cnt_next;
   reg  [CW-1:0] wd_reg;
   reg           an_en_reg;
   reg  [3:0]    adv_reg;
   reg  [15:0]   lpa_reg;
   reg           lpcap_reg;
   reg           pdf_reg;
   reg           nosig_reg;
   reg           slow_reg;
   reg           res100_reg;
   reg           resfd_reg;
   reg           tx_en_reg;
   reg  [15:0]   tx_word_reg;
   reg           t100_reg;
   reg           t10_reg;
   reg           fd_reg;
   reg  [15:0]   rdata_reg;
   reg  [15:0]   rd_mux;
   reg  [2:0]    arb_code;

   wire          wr_ctrl;
   wire          sw_rst;
   wire          restart;
   wire          rd_cstat;
   wire          rd_exp;
   wire          rd_vend;
   wire          cplt;
   wire          sig_none;
   wire          multi;
   wire          only_flp;
   wire          only_nlp;
   wire          only_idle;
   wire          res_ok;
   wire          res_100;
   wire          res_fd;
   wire [3:0]    held;
   wire [3:0]    lpa_ab;
   wire          in_neg;

   assign wr_ctrl  = REG_WR && (REG_ADDR == `ANPD_A_CTRL);
   assign sw_rst   = wr_ctrl && REG_WDATA[`ANPD_B_SWRST];
   // the restart bit is never stored, so it always reads back as zero
   assign restart  = (wr_ctrl && REG_WDATA[`ANPD_B_RESTART]) ||
                     ((state_reg == S_DONE) && !LINK_OK);
   assign rd_cstat = REG_RD && (REG_ADDR == `ANPD_A_CSTAT);
   assign rd_exp   = REG_RD && (REG_ADDR == `ANPD_A_EXP);
   assign rd_vend  = REG_RD && (REG_ADDR == `ANPD_A_VEND);
   assign cplt     = (state_reg == S_DONE);
   assign lpa_ab   = lpa_reg[`ANPD_B_AB_HI:`ANPD_B_AB_LO];
   assign in_neg   = !(state_reg == S_IDLE) && !cplt;

   anpd_detect u_detect (
      .flp       (FLP_RX),
      .nlp       (NLP_RX),
      .idle100   (IDLE100_RX),
      .adv       (adv_reg),
      .lpa       (lpa_ab),
      .sig_none  (sig_none),
      .multi     (multi),
      .only_flp  (only_flp),
      .only_nlp  (only_nlp),
      .only_idle (only_idle),
      .res_ok    (res_ok),
      .res_100   (res_100),
      .res_fd    (res_fd)
   );

   anpd_progress u_progress (
      .clk  (CLK),
      .rst  (SYS_RST),
      .clr  (sw_rst),
      .rd   (rd_cstat),
      .arb  (arb_code),
      .cplt (cplt),
      .held (held)
   );

   // progress value of each arbitration state; higher means further along
   always @* begin
      case (state_reg)
         S_BRK:   arb_code = `ANPD_PC_BRK;
         S_ABL:   arb_code = `ANPD_PC_ABL;
         S_ACK:   arb_code = `ANPD_PC_ACK;
         S_CACK:  arb_code = `ANPD_PC_CACK;
         S_PDET:  arb_code = `ANPD_PC_PDET;
         S_LCHK:  arb_code = `ANPD_PC_LCHK;
         default: arb_code = `ANPD_PC_IDLE;
      endcase
   end

   always @* begin
      state_next = state_reg;
      cnt_next   = cnt_reg + CNT_ONE;
      case (state_reg)
         S_IDLE: begin
            cnt_next = {CW{1'b0}};
            if (an_en_reg) begin
               state_next = S_BRK;
            end
         end
         S_BRK: begin
            if (cnt_reg >= BRK_LAST) begin
               state_next = S_ABL;
               cnt_next   = {CW{1'b0}};
            end
         end
         S_ABL: begin
            if (multi) begin
               cnt_next = {CW{1'b0}};
            end else if (only_flp) begin
               state_next = S_ACK;
               cnt_next   = {CW{1'b0}};
            end else if (only_nlp || only_idle) begin
               state_next = S_PDET;
               cnt_next   = {CW{1'b0}};
            end else if (cnt_reg >= RESP_LAST) begin
               cnt_next = {CW{1'b0}};
            end
         end
         S_ACK: begin
            if (FLP_RX && FLP_WORD[`ANPD_B_ACK]) begin
               state_next = S_CACK;
               cnt_next   = {CW{1'b0}};
            end else if (cnt_reg >= RESP_LAST) begin
               state_next = S_BRK;
               cnt_next   = {CW{1'b0}};
            end
         end
         S_CACK: begin
            cnt_next   = {CW{1'b0}};
            state_next = res_ok ? S_LCHK : S_BRK;
         end
         S_PDET: begin
            cnt_next   = {CW{1'b0}};
            state_next = S_LCHK;
         end
         S_LCHK: begin
            if (LINK_OK) begin
               state_next = S_DONE;
            end else if (cnt_reg >= LINK_LAST) begin
               state_next = S_BRK;
               cnt_next   = {CW{1'b0}};
            end
         end
         S_DONE: begin
            cnt_next = {CW{1'b0}};
         end
         default: begin
            state_next = S_IDLE;
            cnt_next   = {CW{1'b0}};
         end
      endcase
      // clearing enable parks the machine; setting it again starts afresh
      if (!an_en_reg || restart) begin
         state_next = S_IDLE;
         cnt_next   = {CW{1'b0}};
      end
   end

   always @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         state_reg <= S_IDLE;
         cnt_reg   <= {CW{1'b0}};
      end else if (sw_rst) begin
         state_reg <= S_IDLE;
         cnt_reg   <= {CW{1'b0}};
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
      end
   end

   // partner ability and detection results
   always @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         lpa_reg    <= 16'h0000;
         lpcap_reg  <= 1'b0;
         res100_reg <= 1'b0;
         resfd_reg  <= 1'b0;
         nosig_reg  <= 1'b0;
      end else if (sw_rst) begin
         lpa_reg    <= 16'h0000;
         lpcap_reg  <= 1'b0;
         res100_reg <= 1'b0;
         resfd_reg  <= 1'b0;
         nosig_reg  <= 1'b0;
      end else begin
         if ((state_reg == S_ABL || state_reg == S_ACK) && only_flp) begin
            lpa_reg   <= FLP_WORD;
            lpcap_reg <= 1'b1;
         end
         if (state_reg == S_ABL && (only_nlp || only_idle)) begin
            lpa_reg                  <= 16'h0000;
            lpa_reg[`ANPD_B_10H]     <= only_nlp;
            lpa_reg[`ANPD_B_100H]    <= only_idle;
            lpcap_reg                <= 1'b0;
            res100_reg               <= only_idle;
            resfd_reg                <= 1'b0;
         end
         if (state_reg == S_ABL && sig_none && cnt_reg >= RESP_LAST) begin
            lpcap_reg <= 1'b0;
         end
         if (state_reg == S_CACK) begin
            res100_reg <= res_100;
            resfd_reg  <= res_fd;
         end
         // no signal flag follows what the receiver hears while listening
         if (state_reg == S_ABL) begin
            if (!sig_none) begin
               nosig_reg <= 1'b0;
            end else if (cnt_reg >= RESP_LAST) begin
               nosig_reg <= 1'b1;
            end
         end
      end
   end

   // latching flags: a new event wins over the clearing read
   always @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         pdf_reg  <= 1'b0;
         slow_reg <= 1'b0;
         wd_reg   <= {CW{1'b0}};
      end else if (sw_rst) begin
         pdf_reg  <= 1'b0;
         slow_reg <= 1'b0;
         wd_reg   <= {CW{1'b0}};
      end else begin
         if (state_reg == S_ABL && multi) begin
            pdf_reg <= 1'b1;
         end else if (rd_exp) begin
            pdf_reg <= 1'b0;
         end
         // overrun is only a hint: the typical time is not a hard limit
         if (in_neg && wd_reg == TYP_LAST) begin
            slow_reg <= 1'b1;
         end else if (rd_vend) begin
            slow_reg <= 1'b0;
         end
         if (!in_neg) begin
            wd_reg <= {CW{1'b0}};
         end else if (wd_reg != TYP_LAST) begin
            wd_reg <= wd_reg + CNT_ONE;
         end
      end
   end

   // management writes
   always @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         an_en_reg <= 1'b1;
         adv_reg   <= `ANPD_ADV_RST;
      end else if (sw_rst) begin
         an_en_reg <= 1'b1;
         adv_reg   <= `ANPD_ADV_RST;
      end else if (REG_WR) begin
         if (REG_ADDR == `ANPD_A_CTRL) begin
            an_en_reg <= REG_WDATA[`ANPD_B_ANEN];
         end
         if (REG_ADDR == `ANPD_A_ADV) begin
            adv_reg <= REG_WDATA[`ANPD_B_AB_HI:`ANPD_B_AB_LO];
         end
      end
   end

   // line side outputs
   always @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         tx_en_reg   <= 1'b0;
         tx_word_reg <= 16'h0000;
         t100_reg    <= 1'b0;
         t10_reg     <= 1'b0;
         fd_reg      <= 1'b0;
      end else begin
         tx_en_reg <= (state_reg == S_ABL) || (state_reg == S_ACK) ||
                      (state_reg == S_CACK);
         tx_word_reg                                 <= 16'h0000;
         tx_word_reg[`ANPD_B_SEL_HI:0]               <= `ANPD_SEL;
         tx_word_reg[`ANPD_B_AB_HI:`ANPD_B_AB_LO]    <= adv_reg;
         tx_word_reg[`ANPD_B_RF]                     <= LOCAL_FAULT;
         tx_word_reg[`ANPD_B_ACK]                    <= (state_reg == S_ACK) ||
                                                        (state_reg == S_CACK);
         // only the chosen path is powered; the rest stays off
         t100_reg <= (state_reg == S_LCHK || cplt) && res100_reg;
         t10_reg  <= (state_reg == S_LCHK || cplt) && !res100_reg;
         fd_reg   <= (state_reg == S_LCHK || cplt) && resfd_reg;
      end
   end

   assign FLP_TX_EN   = tx_en_reg;
   assign FLP_TX_WORD = tx_word_reg;
   assign TECH_100_EN = t100_reg;
   assign TECH_10_EN  = t10_reg;
   assign FULL_DUPLEX = fd_reg;

   always @* begin
      rd_mux = 16'h0000;
      case (REG_ADDR)
         `ANPD_A_CTRL: begin
            rd_mux[`ANPD_B_ANEN] = an_en_reg;
         end
         `ANPD_A_STAT: begin
            rd_mux[`ANPD_B_CPLT1] = cplt;
            rd_mux[`ANPD_B_RF1]   = lpa_reg[`ANPD_B_RF];
            rd_mux[`ANPD_B_LINK1] = LINK_OK;
         end
         `ANPD_A_ADV: begin
            rd_mux[`ANPD_B_SEL_HI:0]            = `ANPD_SEL;
            rd_mux[`ANPD_B_AB_HI:`ANPD_B_AB_LO] = adv_reg;
            rd_mux[`ANPD_B_RF]                  = LOCAL_FAULT;
         end
         `ANPD_A_LPA: begin
            rd_mux = lpa_reg;
         end
         `ANPD_A_EXP: begin
            rd_mux[`ANPD_B_LPCAP] = lpcap_reg;
            rd_mux[`ANPD_B_PDF]   = pdf_reg;
         end
         `ANPD_A_CSTAT: begin
            rd_mux[`ANPD_B_RATE]                = res100_reg;
            rd_mux[`ANPD_B_DPX]                 = resfd_reg;
            // the held code is returned; the read then reloads it
            rd_mux[`ANPD_B_PM_HI:`ANPD_B_PM_LO] = held[2:0];
            rd_mux[`ANPD_B_CPLT17]              = held[3];
            rd_mux[`ANPD_B_NOSIG]               = nosig_reg;
            rd_mux[`ANPD_B_RF17]                = lpa_reg[`ANPD_B_RF];
            rd_mux[`ANPD_B_LINK17]              = LINK_OK;
         end
         `ANPD_A_VEND: begin
            rd_mux[`ANPD_B_RF]   = lpa_reg[`ANPD_B_RF];
            rd_mux[`ANPD_B_SLOW] = slow_reg;
         end
         default: begin
            rd_mux = 16'h0000;
         end
      endcase
   end

   // read data stand only in the cycle after the strobe
   always @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         rdata_reg <= 16'h0000;
      end else begin
         rdata_reg <= REG_RD ? rd_mux : 16'h0000;
      end
   end

   assign REG_RDATA = rdata_reg;
endmodule

// [tb/anpd_chk.sv]
// assertion checker for the auto-negotiation block
`timescale 1ns/10ps
module anpd_chk (
   input wire        CLK,
   input wire        SYS_RST,
   input wire [4:0]  REG_ADDR,
   input wire [15:0] REG_WDATA,
   input wire        REG_WR,
   input wire        REG_RD,
   input wire [15:0] REG_RDATA,
   input wire        LINK_OK,
   input wire        LOCAL_FAULT,
   input wire        FLP_TX_EN,
   input wire [15:0] FLP_TX_WORD,
   input wire        TECH_100_EN,
   input wire        TECH_10_EN
);
   default clocking @(posedge CLK); endclocking
   default disable iff (SYS_RST);
   wire rd17 = REG_RD && REG_ADDR == 5'h11;
   wire rst0 = REG_WR && REG_ADDR == 5'h00 && REG_WDATA[9] && REG_WDATA[12];
   property p_one_tech; !(TECH_100_EN && TECH_10_EN); endproperty
   a_one_tech: assert property (p_one_tech) else $error("both paths on");
   property p_tx_quiet; FLP_TX_EN |-> !(TECH_100_EN || TECH_10_EN); endproperty
   a_tx_quiet: assert property (p_tx_quiet) else $error("path on in bursts");
   property p_sel; FLP_TX_EN |-> FLP_TX_WORD[4:0] == 5'h01 && !FLP_TX_WORD[15]; endproperty
   a_sel: assert property (p_sel) else $error("burst word field");
   property p_rf_tx; FLP_TX_EN && $past(FLP_TX_EN) |-> FLP_TX_WORD[13] == $past(LOCAL_FAULT);
   endproperty
   a_rf_tx: assert property (p_rf_tx) else $error("fault not sent");
   property p_code;
      rd17 |=> !REG_RDATA[4] || REG_RDATA[13:11] == 3'h7 || REG_RDATA[13:11] == 3'h0;
   endproperty
   a_code: assert property (p_code) else $error("bad progress code");
   property p_link17; rd17 |=> REG_RDATA[0] == $past(LINK_OK); endproperty
   a_link17: assert property (p_link17) else $error("link copy");
   property p_ctrl_rd; REG_RD && REG_ADDR == 5'h00 |=> !REG_RDATA[9]; endproperty
   a_ctrl_rd: assert property (p_ctrl_rd) else $error("restart bit read");
   property p_restart; rst0 |-> ##[1:3] !(FLP_TX_EN || TECH_100_EN || TECH_10_EN);
   endproperty
   a_restart: assert property (p_restart) else $error("no restart");
   c_ten: cover property (TECH_10_EN ##1 LINK_OK);
   c_hun: cover property (TECH_100_EN ##1 LINK_OK);
   c_done: cover property (rd17 ##1 REG_RDATA[4] && REG_RDATA[13:11] == 3'h7);
endmodule
bind anpd_top anpd_chk i_chk (.CLK(CLK), .SYS_RST(SYS_RST), .REG_ADDR(REG_ADDR),
   .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
   .LINK_OK(LINK_OK), .LOCAL_FAULT(LOCAL_FAULT), .FLP_TX_EN(FLP_TX_EN),
   .FLP_TX_WORD(FLP_TX_WORD), .TECH_100_EN(TECH_100_EN), .TECH_10_EN(TECH_10_EN));

// [tb/anpd_partner.sv]
// line partner model for the negotiation bench
`timescale 1ns/10ps
module anpd_partner (
   input  wire        clk,
   input  wire        rst,
   input  wire [2:0]  mode,
   input  wire [3:0]  abil,
   input  wire        rf,
   input  wire        cut,
   input  wire        tx_en,
   input  wire        tech100,
   input  wire        tech10,
   output reg         flp_rx,
   output reg  [15:0] flp_word,
   output wire        nlp_rx,
   output wire        idle_rx,
   output wire        link_ok
);
   // mode 0 silent, 1 legacy 10M, 2 legacy 100M, 3 negotiating, 4 both legacy kinds
   reg  [2:0] up_reg;
   wire       fit = (mode == 3'h1 && tech10) || (mode == 3'h2 && tech100)
                    || (mode == 3'h3 && (tech10 || tech100));
   assign nlp_rx  = mode == 3'h1 || mode == 3'h4;
   assign idle_rx = mode == 3'h2 || mode == 3'h4;
   // link rises a few cycles late, like a slow receiver
   assign link_ok = up_reg == 3'h4;
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         up_reg <= 3'h0;
         flp_rx <= 1'b0;
         flp_word <= 16'h0;
      end else begin
         up_reg <= (!fit || cut) ? 3'h0 : (link_ok ? up_reg : up_reg + 3'h1);
         flp_rx <= mode == 3'h3 && tx_en;
         // ack only once already answering; an unused word keeps toggling
         flp_word <= (mode == 3'h3 && tx_en) ? {1'b0, flp_rx, rf, 4'h0, abil, 5'h01}
                                             : ~flp_word;
      end
   end
endmodule

// [tb/anpd_top_bench.sv]
// self-checking bench for the auto-negotiation block
`timescale 1ns/10ps
module anpd_top_bench;
   reg         CLK, SYS_RST, REG_WR, REG_RD, LOCAL_FAULT, rf, cut;
   reg  [4:0]  REG_ADDR;
   reg  [15:0] REG_WDATA, d;
   reg  [2:0]  mode;
   reg  [3:0]  abil;
   wire [15:0] REG_RDATA, FLP_WORD, FLP_TX_WORD;
   wire        FLP_RX, NLP_RX, IDLE100_RX, LINK_OK, FLP_TX_EN;
   wire        TECH_100_EN, TECH_10_EN, FULL_DUPLEX;
   integer     errors, tests_run, cyc, n;
   anpd_top #(.BREAK_CYC(8), .RESP_CYC(16), .LINK_CYC(16), .TYP_CYC(64)) i_dut (
      .CLK(CLK), .SYS_RST(SYS_RST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
      .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .FLP_RX(FLP_RX),
      .FLP_WORD(FLP_WORD), .NLP_RX(NLP_RX), .IDLE100_RX(IDLE100_RX), .LINK_OK(LINK_OK),
      .LOCAL_FAULT(LOCAL_FAULT), .FLP_TX_EN(FLP_TX_EN), .FLP_TX_WORD(FLP_TX_WORD),
      .TECH_100_EN(TECH_100_EN), .TECH_10_EN(TECH_10_EN), .FULL_DUPLEX(FULL_DUPLEX));
   anpd_partner i_lp (.clk(CLK), .rst(SYS_RST), .mode(mode), .abil(abil), .rf(rf),
      .cut(cut), .tx_en(FLP_TX_EN), .tech100(TECH_100_EN), .tech10(TECH_10_EN),
      .flp_rx(FLP_RX), .flp_word(FLP_WORD), .nlp_rx(NLP_RX), .idle_rx(IDLE100_RX),
      .link_ok(LINK_OK));
   task wrap_up;
      begin
         $display("checks %0d mismatches %0d", tests_run, errors);
         if (errors == 0 && tests_run > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask
   task chk(input [15:0] got, input [15:0] exp);
      begin
         tests_run = tests_run + 1;
         if (got !== exp) begin
            errors = errors + 1;
            $display("unexpected at %0t: %h not %h", $time, got, exp);
         end
      end
   endtask
   task wr(input [4:0] a, input [15:0] v);
      begin
         @(posedge CLK);
         REG_ADDR <= a;
         REG_WDATA <= v;
         REG_WR <= 1'b1;
         @(posedge CLK);
         REG_WR <= 1'b0;
      end
   endtask
   task rd(input [4:0] a);
      begin
         @(posedge CLK);
         REG_ADDR <= a;
         REG_RD <= 1'b1;
         @(posedge CLK);
         REG_RD <= 1'b0;
         #1 d = REG_RDATA;
      end
   endtask
   task rc(input [4:0] a, input [15:0] m, input [15:0] e);
      begin
         rd(a);
         chk(d & m, e);
      end
   endtask
   // polls a status bit as management would, giving up after a bounded count
   task poll(input [4:0] a, input [3:0] b);
      begin
         n = 0;
         rd(a);
         while (d[b] !== 1'b1 && n < 80) begin
            rd(a);
            n = n + 1;
         end
         chk(d[b], 1'b1);
      end
   endtask
   task t_regs;
      begin
         rc(5'h00, 16'h1200, 16'h1000);
         rc(5'h04, 16'h01ff, 16'h01e1);
         wr(5'h02, 16'hffff);
         rc(5'h02, 16'hffff, 16'h0000);
      end
   endtask
   task t_start(input [2:0] m);
      begin
         mode <= m;
         wr(5'h00, 16'h1200);
         rd(5'h11);
      end
   endtask
   task t_pd(input [2:0] m, input [15:0] lpa);
      begin
         t_start(m);
         poll(5'h01, 5);
         rc(5'h05, 16'hffff, lpa);
         rc(5'h06, 16'h0001, 16'h0000);
         chk({TECH_100_EN, TECH_10_EN}, {m == 3'h2, m == 3'h1});
         rc(5'h11, 16'hf811, {m == 3'h2, 15'h3811});
         rc(5'h11, 16'h3810, 16'h0010);
         cut <= 1'b1;
         n = 0;
         while ((TECH_100_EN || TECH_10_EN) && n < 10) begin
            @(posedge CLK);
            #1 n = n + 1;
         end
         chk({TECH_100_EN, TECH_10_EN}, 2'b00);
         cut <= 1'b0;
      end
   endtask
   task t_hold;
      begin
         wr(5'h00, 16'h1200);
         rc(5'h11, 16'h3810, 16'h0010);
         rc(5'h11, 16'h0010, 16'h0000);
         // the held code is nonzero here, so only the reset can clear it
         @(posedge CLK) SYS_RST <= 1'b1;
         @(posedge CLK) SYS_RST <= 1'b0;
         rc(5'h11, 16'h3810, 16'h0000);
      end
   endtask
   task t_flp;
      begin
         abil <= 4'hf;
         rf <= 1'b1;
         wr(5'h04, 16'h0061);
         // the local fault must travel in the outgoing word as well
         @(posedge CLK) LOCAL_FAULT <= 1'b1;
         t_start(3'h3);
         n = 0;
         while (FLP_TX_EN !== 1'b1 && n < 40) begin
            @(posedge CLK);
            #1 n = n + 1;
         end
         chk(FLP_TX_WORD & 16'h21ff, 16'h2061);
         poll(5'h01, 5);
         chk({TECH_100_EN, TECH_10_EN, FULL_DUPLEX}, 3'b011);
         rc(5'h06, 16'h0001, 16'h0001);
         rc(5'h01, 16'h0010, 16'h0010);
         rc(5'h05, 16'h2000, 16'h2000);
         rc(5'h11, 16'hc002, 16'h4002);
         rc(5'h13, 16'h2000, 16'h2000);
         rc(5'h04, 16'h2000, 16'h2000);
         @(posedge CLK) LOCAL_FAULT <= 1'b0;
         rc(5'h04, 16'h2000, 16'h0000);
      end
   endtask
   initial begin
      CLK = 1'b0;
      forever #5 CLK = ~CLK;
   end
   // a hang is cut short well beyond the expected few hundred cycles
   always @(posedge CLK) begin
      cyc = cyc + 1;
      if (cyc == 30000) begin
         $display("unexpected at %0t: run did not finish", $time);
         errors = errors + 1;
         wrap_up;
      end
   end
   initial begin
      {REG_WR, REG_RD, LOCAL_FAULT, rf, cut, REG_ADDR, REG_WDATA} = 0;
      {mode, abil, errors, tests_run, cyc} = 0;
      SYS_RST = 1'b1;
      repeat (20) @(posedge CLK);
      SYS_RST <= 1'b0;
      t_regs;
      t_start(3'h0);
      poll(5'h11, 3);
      t_pd(3'h1, 16'h0020);
      t_hold;
      t_pd(3'h2, 16'h0080);
      t_start(3'h4);
      poll(5'h06, 4);
      chk({TECH_100_EN, TECH_10_EN}, 2'b00);
      // stuck in the listening state, so the overrun hint must come up
      poll(5'h13, 0);
      t_flp;
      // a silent partner after a negotiated link must clear the capable bit
      t_start(3'h0);
      poll(5'h11, 3);
      rc(5'h06, 16'h0001, 16'h0000);
      wrap_up;
   end
endmodule
